// [rtl/pmc_divider.v]
// programmable divider producing a one-cycle enable pulse every div+1 cycles
`include "pmc_regs.vh"
module pmc_divider (
    input wire mclk, // system clock
    input wire reset, // synchronous reset, active high
    input wire run, // divider runs while high
    input wire [`PMC_DIV_W-1:0] div, // period minus one
    output reg tick // one-cycle enable pulse
);
    reg [`PMC_DIV_W-1:0] cnt_q;

    // count up and pulse on wrap
    always @(posedge mclk)
    begin
        if (reset || !run)
        begin
            cnt_q <= {`PMC_DIV_W{1'b0}};
            tick <= 1'b0;
        end
        else if (cnt_q >= div)
        begin
            cnt_q <= {`PMC_DIV_W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// [rtl/pmc_power_reset_clock.v]
// modem power mode, clock enable generation and system reset controller
// How it works
// RULE1: system reset comes from the external pin, the supply monitor or firmware.
// RULE2: the outside party holds the external reset pin low at least eight clocks.
// RULE3: processors leave reset within eight clocks after the pin returns high.
// RULE4: any supply rail below its fail threshold asserts system reset.
// RULE5: a firmware reset request is treated as a full system reset.
// RULE6: there are two power modes and active mode runs baseband and front end fully.
// RULE7: in listening mode only the front end and packet detector stay clocked.
// RULE8: a packet start seen in listening mode switches to active mode.
// RULE9: each idle functional block has its clock gated automatically.
// RULE10: all clocks derive from the single 16 MHz reference through the dividers.
// RULE11: system and front-end dividers are programmed independently.
// RULE12: the front-end sample rate is chosen per band: 400, 1200 or 250 ksps.
// RULE13: receive and transmit sample streams never exceed 1.2 Msps.
// RULE14: each transmit converter sample is a 10-bit word.
// RULE15: active mode returns to listening when traffic ends and no send is pending.
// RULE16: the pin is synchronised and reset releases only when all sources are clear.
`include "pmc_regs.vh"
module pmc_power_reset_clock (
    input wire mclk, // system clock, 125 MHz from the reference pll
    input wire reset, // synchronous power-on reset, active high
    input wire ext_reset_low_pin, // external reset pin, active low
    input wire supply_fail, // supply monitor below threshold
    input wire fw_reset_req, // firmware reset request pulse
    input wire pkt_start, // packet detector saw a packet start
    input wire tx_req, // baseband has a transmission pending
    input wire rx_busy, // reception in progress
    input wire tx_busy, // transmission in progress
    input wire [`PMC_NBLK-1:0] blk_busy, // per-block activity in active mode
    input wire [`PMC_DIV_W-1:0] sys_div, // system clock enable divider
    input wire [1:0] band_sel, // frequency band selection
    input wire [`PMC_SAMPLE_W-1:0] tx_sample, // transmit sample from baseband
    input wire tx_sample_valid, // transmit sample offered
    output wire tx_sample_ready, // transmit sample taken on sample tick
    output reg [`PMC_SAMPLE_W-1:0] dac_word, // 10-bit word to the converter
    output reg dac_strobe, // converter sample strobe
    output reg adc_strobe, // receive sample strobe
    output reg sys_reset, // system reset, active high
    output reg cpu_reset, // processor reset, active high
    output reg mode_active, // high in active mode
    output reg line_front_end_clk_en, // front end clock enable
    output reg detect_clk_en, // packet detector clock enable
    output reg baseband_clk_en, // common baseband clock enable
    output reg [`PMC_NBLK-1:0] blk_clk_en, // per-block clock enables
    output wire sys_tick // system rate enable pulse
);
    // sample period minus one, in system clocks, for a sample rate in ksps
    function [`PMC_DIV_W-1:0] pmc_ksps_div;
        input [31:0] ksps;
        reg [31:0] per;
        begin
            // round up so the strobe rate never exceeds the requested rate
            per = (`PMC_CLK_MHZ * 1000 + ksps - 1) / ksps - 1;
            pmc_ksps_div = per[`PMC_DIV_W-1:0];
        end
    endfunction

    // sample rate of a band in ksps
    function [31:0] pmc_band_ksps;
        input [1:0] band;
        begin
            case (band)
                `PMC_BAND_FCC: pmc_band_ksps = `PMC_KSPS_FCC;
                `PMC_BAND_ARIB: pmc_band_ksps = `PMC_KSPS_ARIB;
                `PMC_BAND_PRIME: pmc_band_ksps = `PMC_KSPS_PRIME;
                default: pmc_band_ksps = `PMC_KSPS_CEN_A;
            endcase
        end
    endfunction

    // sample period for a band, never shorter than the converter limit allows
    function [`PMC_DIV_W-1:0] pmc_band_div;
        input [1:0] band;
        reg [`PMC_DIV_W-1:0] div;
        reg [`PMC_DIV_W-1:0] lim;
        begin
            div = pmc_ksps_div(pmc_band_ksps(band));
            lim = pmc_ksps_div(`PMC_KSPS_MAX);
            if (div < lim)
                pmc_band_div = lim; // RULE13
            else
                pmc_band_div = div;
        end
    endfunction

    // power mode state codes
    localparam MODE_LISTEN = `PMC_MODE_LISTEN;
    localparam MODE_ACTIVE = `PMC_MODE_ACTIVE;

    reg pin_s1_q;
    reg pin_s2_q;
    reg [`PMC_RST_CNT_W-1:0] rel_q;
    reg [`PMC_DIV_W-1:0] fe_div_q;
    reg mode_d;
    wire any_src;
    wire fe_tick;

    // two-stage synchroniser on the reset pin
    always @(posedge mclk)
    begin
        if (reset)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= ext_reset_low_pin; // RULE16
            pin_s2_q <= pin_s1_q;
        end
    end

    // any source asks for reset; the pin must stay low long enough to be seen
    assign any_src = !pin_s2_q || supply_fail || fw_reset_req; // RULE1 RULE2 RULE4 RULE5

    // hold reset while any source is active, release a fixed count later
    always @(posedge mclk)
    begin
        if (reset || any_src)
        begin
            rel_q <= {`PMC_RST_CNT_W{1'b0}}; // RULE16
            sys_reset <= 1'b1;
            cpu_reset <= 1'b1;
        end
        else if (rel_q != `PMC_RST_RELEASE_CYC)
        begin
            rel_q <= rel_q + 1'b1;
            sys_reset <= 1'b1;
            cpu_reset <= 1'b1;
        end
        else
        begin
            sys_reset <= 1'b0;
            cpu_reset <= 1'b0; // RULE3
        end
    end

    // next power mode: wake on a packet or a pending send, sleep once all traffic ends
    always @*
    begin
        mode_d = mode_active;
        case (mode_active)
            MODE_LISTEN:
                if (pkt_start || tx_req)
                    mode_d = MODE_ACTIVE; // RULE8
            MODE_ACTIVE:
                if (!rx_busy && !tx_busy && !tx_req && !pkt_start)
                    mode_d = MODE_LISTEN; // RULE15
            default: mode_d = MODE_LISTEN;
        endcase
    end

    // power mode register, forced to listening while the system is in reset
    always @(posedge mclk)
    begin
        if (sys_reset)
            mode_active <= MODE_LISTEN;
        else
            mode_active <= mode_d; // RULE6
    end

    // clock enables follow mode and block activity
    always @(posedge mclk)
    begin
        if (sys_reset)
        begin
            line_front_end_clk_en <= 1'b0;
            detect_clk_en <= 1'b0;
            baseband_clk_en <= 1'b0;
            blk_clk_en <= {`PMC_NBLK{1'b0}};
        end
        else
        begin
            line_front_end_clk_en <= 1'b1; // RULE7
            detect_clk_en <= 1'b1; // RULE7
            baseband_clk_en <= mode_active; // RULE6
            blk_clk_en <= mode_active ? blk_busy : {`PMC_NBLK{1'b0}}; // RULE9
        end
    end

    // front-end divider latched from band selection
    always @(posedge mclk)
    begin
        if (sys_reset)
            fe_div_q <= pmc_band_div(`PMC_BAND_CEN_A);
        else
            fe_div_q <= pmc_band_div(band_sel); // RULE12
    end

    // independent system and front-end dividers from the reference-derived clock
    pmc_divider u_sys_div (
        .mclk(mclk),
        .reset(sys_reset),
        .run(1'b1),
        .div(sys_div), // RULE10 RULE11
        .tick(sys_tick)
    );

    pmc_divider u_fe_div (
        .mclk(mclk),
        .reset(sys_reset),
        .run(1'b1),
        .div(fe_div_q), // RULE11
        .tick(fe_tick)
    );

    assign tx_sample_ready = fe_tick && mode_active;

    // converter strobes at the sample rate, never faster than 1.2 Msps
    always @(posedge mclk)
    begin
        if (sys_reset)
        begin
            dac_word <= {`PMC_SAMPLE_W{1'b0}};
            dac_strobe <= 1'b0;
            adc_strobe <= 1'b0;
        end
        else
        begin
            adc_strobe <= fe_tick; // RULE13
            dac_strobe <= fe_tick && mode_active; // RULE13
            if (tx_sample_ready && tx_sample_valid)
                dac_word <= tx_sample; // RULE14
        end
    end
endmodule

// [rtl/pmc_regs.vh]
// constants for the modem power, reset and clock controller
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
`define PMC_CLK_MHZ 125
`define PMC_REF_MHZ 16
`define PMC_RST_RELEASE_CYC 4'h4
`define PMC_RST_CNT_W 4
`define PMC_DIV_W 16
`define PMC_BAND_CEN_A 2'h0
`define PMC_BAND_FCC 2'h1
`define PMC_BAND_ARIB 2'h2
`define PMC_BAND_PRIME 2'h3
`define PMC_KSPS_CEN_A 400
`define PMC_KSPS_FCC 1200
`define PMC_KSPS_ARIB 1200
`define PMC_KSPS_PRIME 250
`define PMC_KSPS_MAX 1200
`define PMC_SYS_DIV_RST 16'h0000
`define PMC_SAMPLE_W 10
`define PMC_MODE_LISTEN 1'b0
`define PMC_MODE_ACTIVE 1'b1
`define PMC_NBLK 4
`endif

// [test/pmc_bb_model.sv]
// baseband side model that offers transmit samples
module pmc_bb_model (
    input wire logic mclk, // clock
    input wire logic go, // offer samples
    input wire logic tx_sample_ready, // taken this edge
    output logic [9:0] tx_sample, // offered word
    output logic tx_sample_valid, // word offered
    output logic [9:0] last_word // last word taken
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] nxt = 10'h2a5;
    wire take = tx_sample_valid && tx_sample_ready;
    initial tx_sample_valid = 0;
    initial tx_sample = 10'h15a;
    // hold each word until it is taken; an idle bus inverts its word on every clock
    always @(posedge mclk)
    begin
        if (take)
        begin
            last_word <= tx_sample;
            nxt <= tx_sample + 10'h0d3;
        end
        tx_sample_valid <= #1 go || (tx_sample_valid && !take);
        if (take)
            tx_sample <= #1 tx_sample + 10'h0d3;
        else if (go || tx_sample_valid)
            tx_sample <= #1 nxt;
        else
            tx_sample <= #1 ~tx_sample;
    end
endmodule

// [test/pmc_chk.sv]
// assertions on the controller ports
module pmc_chk (
    input wire mclk, // clock
    input wire reset, // reset
    input wire ext_reset_low_pin, // pin
    input wire supply_fail, // monitor
    input wire fw_reset_req, // firmware
    input wire pkt_start, // packet
    input wire tx_req, // send pending
    input wire rx_busy, // receiving
    input wire tx_busy, // sending
    input wire [3:0] blk_busy, // activity
    input wire [9:0] tx_sample, // sample
    input wire tx_sample_valid, // offered
    input wire tx_sample_ready, // taken
    input wire [9:0] dac_word, // to converter
    input wire dac_strobe, // strobe
    input wire sys_reset, // system reset
    input wire cpu_reset, // cpu reset
    input wire mode_active, // mode
    input wire baseband_clk_en, // gate
    input wire [3:0] blk_clk_en // gates
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] calm_cnt;
    // consecutive cycles with every reset source quiet, saturating at eight
    always @(posedge mclk)
    begin
        if (reset || !ext_reset_low_pin || supply_fail || fw_reset_req)
            calm_cnt <= 4'h0;
        else if (calm_cnt != 4'h8)
            calm_cnt <= calm_cnt + 4'h1;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence take_s;
        tx_sample_valid && tx_sample_ready;
    endsequence
    sequence quiet_s;
        !pkt_start && !tx_req && !rx_busy && !tx_busy;
    endsequence
    src_reset_a: assert property ((fw_reset_req || supply_fail) |=> sys_reset)
        else $error("reset source ignored");
    pin_reset_a: assert property (!ext_reset_low_pin [*5] |-> sys_reset)
        else $error("pin reset ignored");
    cpu_release_a: assert property (calm_cnt >= 4'h7 && ext_reset_low_pin && !supply_fail
        && !fw_reset_req |-> !cpu_reset) else $error("cpu reset held too long");
    release_src_a: assert property ($fell(sys_reset) |-> $past(ext_reset_low_pin, 3)
        && !$past(supply_fail) && !$past(fw_reset_req)) else $error("reset released early");
    go_active_a: assert property (!mode_active && pkt_start && !sys_reset |=> mode_active)
        else $error("no wake on packet");
    back_listen_a: assert property (quiet_s ##0 mode_active |=> !mode_active)
        else $error("no return to listen");
    listen_gate_a: assert property (!mode_active && $past(!mode_active) && !sys_reset
        |-> !baseband_clk_en && blk_clk_en == 4'h0) else $error("clock on in listen");
    blk_gate_a: assert property (mode_active && $past(mode_active) && $stable(blk_busy)
        |-> blk_clk_en == blk_busy) else $error("block gate wrong");
    dac_word_a: assert property (take_s |=> dac_strobe && dac_word == $past(tx_sample))
        else $error("sample not passed");
endmodule
bind pmc_power_reset_clock pmc_chk pmc_chk_inst (.mclk, .reset, .ext_reset_low_pin,
    .supply_fail, .fw_reset_req, .pkt_start, .tx_req, .rx_busy, .tx_busy, .blk_busy,
    .tx_sample, .tx_sample_valid, .tx_sample_ready, .dac_word, .dac_strobe, .sys_reset,
    .cpu_reset, .mode_active, .baseband_clk_en, .blk_clk_en);

// [test/testbench.sv]
// self-checking bench for the power, reset and clock controller
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, reset = 1, ext_reset_low_pin = 1, supply_fail = 0, fw_reset_req = 0;
    logic pkt_start = 0, tx_req = 0, rx_busy = 0, tx_busy = 0, go = 0;
    logic [3:0] blk_busy = 0;
    logic [15:0] sys_div = 0;
    logic [1:0] band_sel = 0;
    wire [9:0] tx_sample, dac_word, last_word;
    wire tx_sample_valid, tx_sample_ready, dac_strobe, adc_strobe, sys_reset, cpu_reset;
    wire mode_active, line_front_end_clk_en, detect_clk_en, baseband_clk_en, sys_tick;
    wire [3:0] blk_clk_en;
    integer n_errors = 0, n_checks = 0, p, i;
    pmc_power_reset_clock pmc_power_reset_clock_inst (.mclk, .reset, .ext_reset_low_pin,
        .supply_fail, .fw_reset_req, .pkt_start, .tx_req, .rx_busy, .tx_busy, .blk_busy,
        .sys_div, .band_sel, .tx_sample, .tx_sample_valid, .tx_sample_ready, .dac_word,
        .dac_strobe, .adc_strobe, .sys_reset, .cpu_reset, .mode_active,
        .line_front_end_clk_en, .detect_clk_en, .baseband_clk_en, .blk_clk_en, .sys_tick);
    pmc_bb_model pmc_bb_model_inst (.mclk, .go, .tx_sample_ready, .tx_sample,
        .tx_sample_valid, .last_word);
    initial forever #4 mclk = ~mclk;
    task step(input integer k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task check(input [15:0] seen, input [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cycles until the next pulse: 0 adc, 1 system tick, 2 dac
    task gap(input integer sel);
        p = 0;
        do
        begin
            step(1);
            p++;
        end while (!(sel == 0 ? adc_strobe : sel == 1 ? sys_tick : dac_strobe) && p < 700);
        if (p >= 700)
        begin
            n_errors++;
            stop_test;
        end
    endtask
    task t_pin;
        ext_reset_low_pin = 0;
        step(8);
        check(cpu_reset, 1, "cpu_reset");
        ext_reset_low_pin = 1;
        step(8);
        check(cpu_reset, 0, "cpu_reset");
        $display("pin done");
    endtask
    task t_src;
        for (i = 0; i < 2; i++)
        begin
            supply_fail = (i == 0);
            fw_reset_req = (i == 1);
            step(1);
            fw_reset_req = 0;
            step(1);
            check(sys_reset, 1, "sys_reset");
            supply_fail = 0;
            step(8);
            check(sys_reset, 0, "sys_reset");
        end
        $display("sources done");
    endtask
    task t_mode;
        check(line_front_end_clk_en & detect_clk_en & !baseband_clk_en, 1, "listen");
        pkt_start = 1;
        step(1);
        pkt_start = 0;
        rx_busy = 1;
        blk_busy = 4'h5;
        step(2);
        check({mode_active, baseband_clk_en, blk_clk_en}, 6'h35, "active");
        rx_busy = 0;
        tx_req = 1;
        step(3);
        check({mode_active, blk_clk_en}, 5'h15, "mode");
        tx_req = 0;
        step(3);
        check({mode_active, baseband_clk_en, blk_clk_en}, 0, "listen");
        blk_busy = 0;
        $display("mode done");
    endtask
    task t_clk;
        sys_div = 4;
        gap(1);
        gap(1);
        check(p, 5, "sys period");
        for (i = 0; i < 4; i++)
        begin
            band_sel = i;
            gap(0);
            gap(0);
            gap(0);
            check(p, i == 0 ? 313 : i == 3 ? 500 : 105, "fe period");
        end
        $display("clocks done");
    endtask
    task t_tx;
        tx_req = 1;
        tx_busy = 1;
        go = 1;
        band_sel = 1;
        gap(2);
        gap(2);
        check(p, 105, "dac period");
        check(dac_word, last_word, "dac_word");
        check(dac_word, 16'h0378, "dac_word");
        go = 0;
        tx_req = 0;
        tx_busy = 0;
        $display("transmit done");
    endtask
    initial
    begin
        step(8);
        check(sys_reset, 1, "sys_reset");
        reset = 0;
        step(8);
        check(sys_reset, 0, "sys_reset");
        t_pin;
        t_src;
        t_mode;
        t_clk;
        t_tx;
        stop_test;
    end
endmodule
